/* design/ust_pkg.sv */
// Package of offsets, field positions, reset values and timing for the serial transmit block.
package ust_pkg;

   // ****************************************************
   // Clock and timing
   // ****************************************************
   localparam int CLK_NS          = 40;
   localparam int MASTER_HALF_NS  = 160;
   localparam int ASYNC_HI_NS     = 1280;
   localparam int ASYNC_LO_NS     = 5120;
   localparam logic [7:0] MASTER_HALF_CYC = 8'((MASTER_HALF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] ASYNC_HI_CYC    = 8'((ASYNC_HI_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] ASYNC_LO_CYC    = 8'((ASYNC_LO_NS + CLK_NS - 1) / CLK_NS);

   // ****************************************************
   // Register byte addresses
   // ****************************************************
   localparam logic [7:0] ADDR_HOLD   = 8'h00;
   localparam logic [7:0] ADDR_RXCS   = 8'h04;
   localparam logic [7:0] ADDR_PINDIR = 8'h08;
   localparam logic [7:0] ADDR_ISTAT  = 8'h0c;
   localparam logic [7:0] ADDR_IMASK  = 8'h10;
   localparam logic [7:0] ADDR_TXCS   = 8'h98;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int TXCS_CLKSRC = 7;
   localparam int TXCS_NINE   = 6;
   localparam int TXCS_TRANSMIT_ENABLE   = 5;
   localparam int TXCS_SYNC   = 4;
   localparam int TXCS_BRGH   = 2;
   localparam int TXCS_SHIFT_EMPTY_STATUS   = 1;
   localparam int TXCS_NINTH  = 0;
   localparam int RXCS_PEN    = 7;
   localparam int RXCS_SINGLE_RECEIVE_ENABLE   = 5;
   localparam int RXCS_CONTINUOUS_RECEIVE_ENABLE   = 4;
   localparam int PIN_CLK     = 2;
   localparam int PIN_DATA    = 1;
   localparam int ISTAT_TXEV  = 0;
   localparam int ISTAT_TRANSMIT_BUFFER_EMPTY_FLAG  = 8;
   localparam int IMASK_TRANSMIT_INTERRUPT_ENABLE  = 0;
   localparam int IMASK_GIE   = 7;

   // ****************************************************
   // Reset values and bus answers
   // ****************************************************
   localparam logic [7:0] TXCS_RST   = 8'h00;
   localparam logic [7:0] RXCS_RST   = 8'h00;
   localparam logic [7:0] PINDIR_RST = 8'hff;
   localparam logic [7:0] IMASK_RST  = 8'h00;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;

   // Bus channel states.
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_RESP = 2'b10
   } ust_bus_st_t;

endpackage : ust_pkg

/* design/ust_serial_tx.sv */
// Serial port transmit block with AXI4-Lite registers, holding register and pin control.
`timescale 1ns/1ps

// Overview of operation
// RULE1: Pins serve the port only with port enable and both direction bits set.
// RULE2: Asynchronous, synchronous master and synchronous slave modes are supported.
// RULE3: Eight-bit transmit control and status register at address 98h.
// RULE4: Slave mode shifts on the external clock pin and never drives it.
// RULE5: Clearing clock source select, bit 7, selects synchronous slave operation.
// RULE6: Slave shifting continues while the core sleeps.
// RULE7: Slave transmit matches master transmit except during sleep.
// RULE8: A word written while the shifter idles moves into it at once.
// RULE9: A second word waits in the holding register; buffer-empty flag stays clear.
// RULE10: After the shift ends the held word loads and buffer-empty flag sets.
// RULE11: Enabled transmit flag raises a wake interrupt; with global enable, vector branch.
// RULE12: Software sets both direction bits; the port drives the pins itself.
// RULE13: Software sets sync and port enable and clears clock source for slave.
// RULE14: Software clears both receive enables during slave transmit setup.
// RULE15: Software sets nine-bit select and the ninth bit before loading data.
// RULE16: Software sets transmit enable then writes each data byte.
// RULE17: Shift-empty status reads 1 when shifter is empty; resets to 1.
// RULE18: In synchronous mode any receive enable suppresses transmission.
// RULE19: Nine-bit select shifts nine bits, ninth from its field; else eight.
module ust_serial_tx (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        coreSleep,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        serialClockPinIn,
   output logic             serialClockPinOut,
   output logic             serialClockPinOe,
   input  wire logic        serialDataPinIn,
   output logic             serialDataPinOut,
   output logic             serialDataPinOe,
   output logic             irq,
   output logic             branchReq
);

   // ****************************************************
   // Declarations
   // ****************************************************
   ust_pkg::ust_bus_st_t wrSt_q;
   ust_pkg::ust_bus_st_t rdSt_q;
   logic [7:0]  txcs_q;
   logic [7:0]  rxcs_q;
   logic [7:0]  pinDir_q;
   logic [7:0]  imask_q;
   logic [7:0]  hold_q;
   logic        holdFull_q;
   logic        txEvent_q;
   logic        awGot_q;
   logic        wGot_q;
   logic [7:0]  awAddr_q;
   logic [31:0] wData_q;
   logic        wLane_q;
   logic        awFire;
   logic        wFire;
   logic        wrDo;
   logic [7:0]  wrAddr;
   logic [7:0]  wrByte;
   logic        wrLane;
   logic        wrHit;
   logic [31:0] rdMux;
   logic        rdHit;
   logic [1:0]  pinSync;
   logic        extClkPrev_q;
   logic        mClk_q;
   logic [7:0]  divCnt_q;
   logic        tick;
   logic        shLoad;
   logic        shBusy;
   logic        shBit;
   logic [10:0] frame;
   logic [3:0]  frameLen;
   logic        portOn;
   logic        syncMode;
   logic        masterMode;
   logic        txAllowed;
   logic        slaveFall;
   logic        masterFall;
   logic [7:0]  baudCyc;
   logic        holdEmptyEvt;

   // ****************************************************
   // Mode decode
   // ****************************************************
   // Port is routed to the pins only with enable and both direction bits set.
   assign portOn     = rxcs_q[ust_pkg::RXCS_PEN] && pinDir_q[ust_pkg::PIN_CLK]
                       && pinDir_q[ust_pkg::PIN_DATA]; // RULE1 RULE12
   assign syncMode   = txcs_q[ust_pkg::TXCS_SYNC]; // RULE2
   assign masterMode = syncMode && txcs_q[ust_pkg::TXCS_CLKSRC]; // RULE5
   // A receive enable wins over transmit enable in synchronous mode.
   assign txAllowed  = txcs_q[ust_pkg::TXCS_TRANSMIT_ENABLE] && portOn && !(syncMode
                       && (rxcs_q[ust_pkg::RXCS_SINGLE_RECEIVE_ENABLE] || rxcs_q[ust_pkg::RXCS_CONTINUOUS_RECEIVE_ENABLE])); // RULE18

   // ****************************************************
   // Shift clock sources
   // ****************************************************
   // The pins arrive from another domain and are resynchronised first.
   ust_sync2 #(
      .WIDTH (2)
   ) u_pinSync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .asyncIn ({serialDataPinIn, serialClockPinIn}),
      .syncOut (pinSync)
   );

   // Edge detector on the synchronised external clock.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         extClkPrev_q <= 1'b0;
      end else begin
         extClkPrev_q <= pinSync[0];
      end
   end

   // Slave shifts on the falling edge of the external clock, sleep or not.
   assign slaveFall  = syncMode && !masterMode && extClkPrev_q && !pinSync[0]; // RULE4 RULE6
   assign masterFall = masterMode && mClk_q && (divCnt_q == 8'h1);
   assign baudCyc    = txcs_q[ust_pkg::TXCS_BRGH] ? ust_pkg::ASYNC_HI_CYC
                                                 : ust_pkg::ASYNC_LO_CYC;

   // Internal divider: master clock halves, or asynchronous bit periods.
   // It stops in sleep, so only the slave keeps shifting then.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_q <= 8'h0;
         mClk_q   <= 1'b0;
      end else if (!shBusy || coreSleep || (syncMode && !masterMode)) begin
         divCnt_q <= masterMode ? ust_pkg::MASTER_HALF_CYC : baudCyc;
         mClk_q   <= 1'b0;
      end else if (divCnt_q == 8'h1) begin
         divCnt_q <= masterMode ? ust_pkg::MASTER_HALF_CYC : baudCyc;
         mClk_q   <= masterMode ? !mClk_q : 1'b0;
      end else begin
         divCnt_q <= divCnt_q - 8'h1;
      end
   end

   // Master and slave share the one shifter and tick rule.
   assign tick = syncMode ? (masterMode ? masterFall : slaveFall)
                          : (divCnt_q == 8'h1); // RULE7

   // ****************************************************
   // Frame building and shifter
   // ****************************************************
   // Synchronous frames are eight or nine data bits; async adds start and stop.
   always_comb begin
      frame    = 11'h7ff;
      frameLen = 4'h8;
      if (syncMode) begin
         frame    = {2'b11, txcs_q[ust_pkg::TXCS_NINTH], hold_q};
         frameLen = txcs_q[ust_pkg::TXCS_NINE] ? 4'h9 : 4'h8; // RULE19
      end else if (txcs_q[ust_pkg::TXCS_NINE]) begin
         frame    = {1'b1, txcs_q[ust_pkg::TXCS_NINTH], hold_q, 1'b0}; // RULE19
         frameLen = 4'hb;
      end else begin
         frame    = {2'b11, hold_q, 1'b0};
         frameLen = 4'ha;
      end
   end

   // Held word moves in as soon as the shifter is idle and transmit is allowed.
   assign shLoad = holdFull_q && !shBusy && txAllowed; // RULE8 RULE10

   ust_tx_shift u_shift (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .load      (shLoad),
      .loadFrame (frame),
      .loadLen   (frameLen),
      .tick      (tick),
      .busy      (shBusy),
      .bitOut    (shBit)
   );

   // ****************************************************
   // Holding register and transmit flag
   // ****************************************************
   // Holding register stays full while the shifter is busy.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q     <= 8'h00;
         holdFull_q <= 1'b0;
      end else if (wrDo && wrHit && wrLane && wrAddr == ust_pkg::ADDR_HOLD) begin
         hold_q     <= wrByte;
         holdFull_q <= 1'b1; // RULE9
      end else if (shLoad) begin
         holdFull_q <= 1'b0; // RULE10
      end
   end

   assign holdEmptyEvt = shLoad;

   // Sticky event bit; a new event wins over a clear in the same cycle.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txEvent_q <= 1'b0;
      end else begin
         txEvent_q <= holdEmptyEvt || (txEvent_q && !(wrDo && wrHit && wrLane
                      && wrAddr == ust_pkg::ADDR_ISTAT && wrByte[ust_pkg::ISTAT_TXEV]));
      end
   end

   // Interrupt wakes the core; branch request also needs global enable.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq       <= 1'b0;
         branchReq <= 1'b0;
      end else begin
         irq       <= txEvent_q && imask_q[ust_pkg::IMASK_TRANSMIT_INTERRUPT_ENABLE]; // RULE11
         branchReq <= txEvent_q && imask_q[ust_pkg::IMASK_TRANSMIT_INTERRUPT_ENABLE]
                      && imask_q[ust_pkg::IMASK_GIE]; // RULE11
      end
   end

   // ****************************************************
   // Pin drive
   // ****************************************************
   // Data is driven whenever transmit is allowed, idle or shifting; the clock only in master mode.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         serialDataPinOut  <= 1'b1;
         serialDataPinOe   <= 1'b0;
         serialClockPinOut <= 1'b0;
         serialClockPinOe  <= 1'b0;
      end else begin
         serialDataPinOut  <= shBit;
         serialDataPinOe   <= portOn && txAllowed; // RULE1 RULE12
         serialClockPinOut <= mClk_q;
         serialClockPinOe  <= portOn && masterMode && txAllowed; // RULE4
      end
   end

   // ****************************************************
   // AXI4-Lite write channel
   // ****************************************************
   assign awFire = s_axi_awvalid && s_axi_awready;
   assign wFire  = s_axi_wvalid && s_axi_wready;
   assign wrDo   = (awGot_q || awFire) && (wGot_q || wFire) && wrSt_q == ust_pkg::BUS_IDLE;
   assign wrAddr = awFire ? s_axi_awaddr : awAddr_q;
   assign wrByte = wFire ? s_axi_wdata[7:0] : wData_q[7:0];
   assign wrLane = wFire ? s_axi_wstrb[0] : wLane_q;
   assign wrHit  = wrAddr == ust_pkg::ADDR_HOLD || wrAddr == ust_pkg::ADDR_RXCS
                   || wrAddr == ust_pkg::ADDR_PINDIR || wrAddr == ust_pkg::ADDR_ISTAT
                   || wrAddr == ust_pkg::ADDR_IMASK || wrAddr == ust_pkg::ADDR_TXCS;

   // Address and data may come in either order; the answer follows both.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrSt_q        <= ust_pkg::BUS_IDLE;
         awGot_q       <= 1'b0;
         wGot_q        <= 1'b0;
         awAddr_q      <= 8'h00;
         wData_q       <= 32'h0;
         wLane_q       <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ust_pkg::RESP_OKAY;
      end else begin
         case (wrSt_q)
            ust_pkg::BUS_IDLE: begin
               if (awFire) begin
                  awGot_q       <= 1'b1;
                  awAddr_q      <= s_axi_awaddr;
                  s_axi_awready <= 1'b0;
               end
               if (wFire) begin
                  wGot_q       <= 1'b1;
                  wData_q      <= s_axi_wdata;
                  wLane_q      <= s_axi_wstrb[0];
                  s_axi_wready <= 1'b0;
               end
               if (wrDo) begin
                  awGot_q       <= 1'b0;
                  wGot_q        <= 1'b0;
                  s_axi_awready <= 1'b0;
                  s_axi_wready  <= 1'b0;
                  s_axi_bvalid  <= 1'b1;
                  s_axi_bresp   <= wrHit ? ust_pkg::RESP_OKAY : ust_pkg::RESP_SLV;
                  wrSt_q        <= ust_pkg::BUS_RESP;
               end
            end
            ust_pkg::BUS_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid  <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready  <= 1'b1;
                  wrSt_q        <= ust_pkg::BUS_IDLE;
               end
            end
            default: begin
               wrSt_q <= ust_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   // Control registers; the shift-empty bit is not stored.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         txcs_q   <= ust_pkg::TXCS_RST;
         rxcs_q   <= ust_pkg::RXCS_RST;
         pinDir_q <= ust_pkg::PINDIR_RST;
         imask_q  <= ust_pkg::IMASK_RST;
      end else if (wrDo && wrLane) begin
         case (wrAddr)
            ust_pkg::ADDR_TXCS:   txcs_q   <= wrByte & 8'hf5; // RULE3
            ust_pkg::ADDR_RXCS:   rxcs_q   <= wrByte & 8'hb0;
            ust_pkg::ADDR_PINDIR: pinDir_q <= wrByte;
            ust_pkg::ADDR_IMASK:  imask_q  <= wrByte & 8'h81;
            default:              txcs_q   <= txcs_q;
         endcase
      end
   end

   // ****************************************************
   // AXI4-Lite read channel
   // ****************************************************
   // Read mux; unmapped addresses read zero with an error answer.
   always_comb begin
      rdMux = 32'h0;
      rdHit = 1'b1;
      case (s_axi_araddr)
         ust_pkg::ADDR_TXCS:   rdMux[7:0] = txcs_q | {6'h0, !shBusy, 1'b0}; // RULE3 RULE17
         ust_pkg::ADDR_HOLD:   rdMux[7:0] = hold_q;
         ust_pkg::ADDR_RXCS:   rdMux[7:0] = rxcs_q;
         ust_pkg::ADDR_PINDIR: rdMux[7:0] = pinDir_q;
         ust_pkg::ADDR_ISTAT:  rdMux[8:0] = {!holdFull_q, 7'h0, txEvent_q}; // RULE9
         ust_pkg::ADDR_IMASK:  rdMux[7:0] = imask_q;
         default:              rdHit      = 1'b0;
      endcase
   end

   // One read at a time, answered the cycle after the address is taken.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdSt_q        <= ust_pkg::BUS_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= ust_pkg::RESP_OKAY;
      end else begin
         case (rdSt_q)
            ust_pkg::BUS_IDLE: begin
               if (s_axi_arvalid) begin
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rdata   <= rdMux;
                  s_axi_rresp   <= rdHit ? ust_pkg::RESP_OKAY : ust_pkg::RESP_SLV;
                  rdSt_q        <= ust_pkg::BUS_RESP;
               end
            end
            ust_pkg::BUS_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid  <= 1'b0;
                  s_axi_arready <= 1'b1;
                  rdSt_q        <= ust_pkg::BUS_IDLE;
               end
            end
            default: begin
               rdSt_q <= ust_pkg::BUS_IDLE;
            end
         endcase
      end
   end

endmodule : ust_serial_tx

/* design/ust_sync2.sv */
// Two-flop synchroniser, one chain per bit.
`timescale 1ns/1ps
module ust_sync2 #(
   parameter int WIDTH = 2
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   // ****************************************************
   // Per-bit chains
   // ****************************************************
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_q;
         // The first stage feeds only the second stage.
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_q     <= 1'b0;
               syncOut[i] <= 1'b0;
            end else begin
               meta_q     <= asyncIn[i];
               syncOut[i] <= meta_q;
            end
         end
      end
   endgenerate

endmodule : ust_sync2

/* design/ust_tx_shift.sv */
// Transmit shift register: loads a frame and shifts it out LSB first on each tick.
`timescale 1ns/1ps
module ust_tx_shift (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        load,
   input  wire logic [10:0] loadFrame,
   input  wire logic [3:0]  loadLen,
   input  wire logic        tick,
   output logic            busy,
   output logic            bitOut
);

   logic [10:0] frame_q;
   logic [3:0]  left_q;

   // ****************************************************
   // Shifting
   // ****************************************************
   // The current bit sits on bitOut; each tick moves to the next one.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_q <= 11'h7ff;
         left_q  <= 4'h0;
         busy    <= 1'b0;
      end else if (load) begin
         frame_q <= loadFrame;
         left_q  <= loadLen;
         busy    <= 1'b1;
      end else if (tick && busy) begin
         frame_q <= {1'b1, frame_q[10:1]};
         left_q  <= left_q - 4'h1;
         busy    <= (left_q != 4'h1);
      end
   end

   assign bitOut = busy ? frame_q[0] : 1'b1;

endmodule : ust_tx_shift

/* sim/test_ust_serial_tx.sv */
// Testbench of the serial transmit block in slave mode, plus a pin-enable table over slave, master and async settings.
`timescale 1ns/1ps
module test_ust_serial_tx;
   logic ref_clk = 1'h0, rst_n = 1'h0, coreSleep = 1'h0, lastD = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, branchReq, extCk;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic serialClockPinIn, serialClockPinOut, serialClockPinOe;
   logic serialDataPinIn, serialDataPinOut, serialDataPinOe;
   logic [31:0] seed = 32'hdac81593;
   logic [8:0] expQ[$];
   logic [25:0] cfg[8] = '{26'h13080ff, 26'h3b080ff, 26'h12080ff, 26'h30a0ff,
                           26'h3090ff, 26'h3000ff, 26'h3080fb, 26'h3080fd};
   int err_count = 0, samples_checked = 0, cycles = 0;
   ust_serial_tx ust_serial_tx_inst (.ref_clk, .rst_n, .coreSleep, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .serialClockPinIn, .serialClockPinOut, .serialClockPinOe,
      .serialDataPinIn, .serialDataPinOut, .serialDataPinOe, .irq, .branchReq);
   ust_ext_master ust_ext_master_inst (.extCk, .dataIn(serialDataPinIn));
   // Clock; a released data line reads inverted.
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (serialDataPinOe) lastD <= serialDataPinOut;
   assign serialDataPinIn = serialDataPinOe ? serialDataPinOut : ~lastD;
   assign serialClockPinIn = serialClockPinOe ? serialClockPinOut : extCk;
   // Hang guard.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 8000) begin
         err_count++;
         end_of_test();
      end
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic chk(input logic [31:0] seen, exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: %s seen %h want %h", $time, msg, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge ref_clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      forever begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, er, "write response");
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed);
      @(posedge ref_clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      forever begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, ed, "read data");
      chk(s_axi_rresp, 32'h0, "read response");
   endtask : rd
   task automatic send(input logic nine);
      seed = nxt(seed);
      expQ.push_back({nine, seed[7:0]});
      wr(ust_pkg::ADDR_HOLD, {24'h0, seed[7:0]}, 2'h0);
   endtask : send
   task automatic take(input int n);
      logic [8:0] got;
      repeat (4) @(posedge ref_clk);
      chk(serialClockPinOe, 1'h0, "clock pin driven");
      ust_ext_master_inst.frame(n, got);
      chk(got, expQ.pop_front(), "frame bits");
      repeat (12) @(posedge ref_clk);
   endtask : take
   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // Main sequence of tests.
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'h1;
      rd(ust_pkg::ADDR_TXCS, 32'h2);
      rd(ust_pkg::ADDR_PINDIR, 32'hff);
      wr(8'h40, seed, 2'h2);
      $display("reset test done");
      wr(ust_pkg::ADDR_RXCS, 32'h80, 2'h0);
      wr(ust_pkg::ADDR_IMASK, 32'h81, 2'h0);
      wr(ust_pkg::ADDR_TXCS, 32'h30, 2'h0);
      coreSleep <= 1'h1;
      send(1'h0);
      send(1'h0);
      rd(ust_pkg::ADDR_ISTAT, 32'h1);
      rd(ust_pkg::ADDR_TXCS, 32'h30);
      wr(ust_pkg::ADDR_ISTAT, 32'h1, 2'h0);
      repeat (3) @(posedge ref_clk);
      chk(irq, 1'h0, "irq after clear");
      take(8);
      rd(ust_pkg::ADDR_ISTAT, 32'h101);
      chk(irq, 1'h1, "wake request");
      chk(branchReq, 1'h1, "branch request");
      take(8);
      rd(ust_pkg::ADDR_TXCS, 32'h32);
      wr(ust_pkg::ADDR_IMASK, 32'h0, 2'h0);
      repeat (3) @(posedge ref_clk);
      chk(irq, 1'h0, "masked irq");
      coreSleep <= 1'h0;
      $display("queued words test done");
      wr(ust_pkg::ADDR_TXCS, {31'h38, seed[9]}, 2'h0);
      send(seed[9]);
      take(9);
      $display("nine-bit test done");
      foreach (cfg[i]) begin
         wr(ust_pkg::ADDR_TXCS, {24'h0, cfg[i][23:16]}, 2'h0);
         wr(ust_pkg::ADDR_RXCS, {24'h0, cfg[i][15:8]}, 2'h0);
         wr(ust_pkg::ADDR_PINDIR, {24'h0, cfg[i][7:0]}, 2'h0);
         repeat (3) @(posedge ref_clk);
         chk(serialDataPinOe, cfg[i][24], "data enable");
         chk(serialClockPinOe, cfg[i][25], "clock enable");
      end
      $display("enable table test done");
      end_of_test();
   end
endmodule : test_ust_serial_tx

/* sim/ust_ext_master.sv */
// External master clocking the slave transmitter and sampling its data.
`timescale 1ns/1ps
module ust_ext_master (
   output logic      extCk,
   input  wire logic dataIn
);
   // The clock idles low between frames.
   initial extCk = 1'h0;
   // Rising edges sample a bit; falling edges ask for the next.
   task automatic frame(input int n, output logic [8:0] v);
      v = 9'h000;
      #7;
      for (int i = 0; i < n; i++) begin
         #160 extCk = 1'h1;
         v[i] = dataIn;
         #160 extCk = 1'h0;
      end
   endtask : frame
endmodule : ust_ext_master

/* sim/ust_serial_tx_chk.sv */
// Checker of bus handshakes, pin enables and interrupts.
`timescale 1ns/1ps
module ust_serial_tx_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serialClockPinOe,
   input wire logic serialDataPinOe,
   input wire logic irq,
   input wire logic branchReq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Bus answers follow one cycle later and stand until taken.
   property p_bAns; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
   a_bAns: assert property (p_bAns) else $error("write answer late");
   property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bHold: assert property (p_bHold) else $error("write answer dropped");
   property p_bDone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
   a_bDone: assert property (p_bDone) else $error("write answer stuck");
   property p_rAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_rAns: assert property (p_rAns) else $error("read answer late");
   property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   a_rHold: assert property (p_rHold) else $error("read answer dropped");
   property p_rDone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
   a_rDone: assert property (p_rDone) else $error("read answer stuck");
   // Clock drive implies data drive.
   property p_clkOe; serialClockPinOe |-> serialDataPinOe; endproperty
   a_clkOe: assert property (p_clkOe) else $error("clock without data");
   // Branch implies interrupt.
   property p_branch; branchReq |-> irq; endproperty
   a_branch: assert property (p_branch) else $error("branch without interrupt");
   c_irq: cover property (irq);
   c_branch: cover property (branchReq);
   c_dataOe: cover property ($rose(serialDataPinOe));
endmodule : ust_serial_tx_chk

bind ust_serial_tx ust_serial_tx_chk ust_serial_tx_chk_inst (.ref_clk, .rst_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .serialClockPinOe, .serialDataPinOe, .irq, .branchReq);
